// *** dv/hdlc_rx_model.sv ***
// behavioural hdlc receive units: shift in each link's bits
`timescale 1ns/100ps
module hdlc_rx_model
(
   input wire logic clk, clr,
   input wire logic [rx_link_pkg::NUM_LINKS-1:0] linkData, linkStrobe,
   output logic     [rx_link_pkg::NUM_LINKS-1:0][7:0] bits_ff,
   output logic     [rx_link_pkg::NUM_LINKS-1:0][4:0] cnt_ff
);
   import rx_link_pkg::*;
   // a count wider than one slot shows bits leaking from a wrong slot
   always_ff @(posedge clk)
      for (int g = 0; g < NUM_LINKS; g++)
         if (clr) {bits_ff[g], cnt_ff[g]} <= 13'h0;
         else if (linkStrobe[g])
            {bits_ff[g], cnt_ff[g]} <=
               {bits_ff[g][6:0], linkData[g], cnt_ff[g] + 5'h1};
endmodule // hdlc_rx_model

// *** dv/rx_data_link_extractor_tb.sv ***
// self-checking bench of the receive data link extractor
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
   num_errors++; $display("mismatch %s exp %h got %h", n, e, s); end end
module rx_data_link_extractor_tb;
   import rx_link_pkg::*;
   typedef struct packed {logic [1:0] k; logic [7:0] c, m; logic e;
      logic [4:0] f; logic [7:0] b, x; logic [4:0] n;} row_t;
   row_t rows [7] = '{'{1,8'h85,8'hFF,0,2,8'hA5,8'hA5,8},
      '{2,8'h97,8'hFF,0,3,8'hA5,0,0}, '{0,8'h40,8'hF0,0,1,8'hC3,8'h0C,4},
      '{1,8'h5F,8'hFF,1,0,8'hA5,0,0}, '{2,8'hD0,8'h81,1,15,8'h81,3,2},
      '{1,8'h05,8'hFF,0,2,8'hA5,0,0}, '{0,8'h8A,8'h01,0,24,8'h01,1,1}};
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, modelClr = 0;
   logic rxBitValid = 0, rxData = 0, rxFramingLinkBit = 0, perr;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic [4:0] rxSlot = '0, rxFrameNum = '0;
   logic [2:0] rxBitIdx = '0;
   logic pready, pslverr;
   logic [NUM_LINKS-1:0] linkData, linkStrobe;
   logic [NUM_LINKS-1:0][7:0] gotBits;
   logic [NUM_LINKS-1:0][4:0] gotCnt;
   int num_errors = 0, comparisons = 0, cycles = 0;
   rx_link_extractor u_rx_link_extractor (.clk, .rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxBitValid,
      .rxData, .rxSlot, .rxBitIdx, .rxFrameNum, .rxFramingLinkBit,
      .linkData, .linkStrobe);
   hdlc_rx_model u_hdlc_rx_model (.clk, .clr(modelClr), .linkData,
      .linkStrobe, .bits_ff(gotBits), .cnt_ff(gotCnt));
   always #5 clk = ~clk;
   task automatic apb(input logic w, input logic [7:0] i, d);
      @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'h0, i,
         2'h0, 24'h0, d};
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      {r, perr} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   // one slot, first received bit (mask bit 7) first
   task automatic slot(input logic [4:0] s, f, input logic [7:0] b);
      @(posedge clk) modelClr <= 1'b0;
      for (int i = 0; i < 8; i++)
         @(posedge clk) {rxBitValid, rxSlot, rxBitIdx, rxFrameNum, rxData}
            <= {1'b1, s, 3'(i), f, b[7-i]};
      @(posedge clk) rxBitValid <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 8'h28; i <= 8'h2E; i++)
      begin
         apb(0, 8'(i), 0);
         `CHK("reset value", i == 8'h28 ? RST_CTRL1 : 8'h0, r[7:0])
      end
      $display("reset values done");
      foreach (rows[j])
      begin
         apb(1, IDX_MODE, 8'(rows[j].e));
         apb(1, IDX_LINK1_CTRL + {5'h0, rows[j].k, 1'b0}, rows[j].c);
         apb(1, IDX_LINK1_MASK + {5'h0, rows[j].k, 1'b0}, rows[j].m);
         apb(0, IDX_LINK1_MASK + {5'h0, rows[j].k, 1'b0}, 0);
         `CHK("mask", rows[j].m, r[7:0])
         modelClr <= 1'b1;
         slot(rows[j].c[4:0], rows[j].f, rows[j].b);
         slot(rows[j].c[4:0] ^ 5'h1, rows[j].f, ~rows[j].b);
         repeat (3) @(posedge clk);
         `CHK("bits", rows[j].x, gotBits[rows[j].k])
         `CHK("counts", 15'(rows[j].n) << 5 * rows[j].k, gotCnt)
         apb(1, IDX_LINK1_CTRL + {5'h0, rows[j].k, 1'b0}, 0);
         $display("row %0d done", j);
      end
      for (int e = 0; e < 2; e++)
      begin
         apb(1, IDX_MODE, 8'(e));
         apb(1, IDX_LINK1_CTRL, 8'h29);
         {modelClr, rxFramingLinkBit} <= 2'b11;
         slot(5'd9, 5'd4, 8'h96);
         repeat (3) @(posedge clk);
         `CHK("framing link", e ? 23'h0 : 23'h4B0008, {gotBits[0], gotCnt})
         rxFramingLinkBit <= 1'b0;
      end
      apb(0, 8'h30, 0);
      `CHK("unmapped", 33'h100000000, {perr, r})
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(0, IDX_LINK1_CTRL, 0);
      `CHK("second reset", RST_CTRL1, r[7:0])
      $display("hand tests done");
      tally_and_finish;
   end
   // the whole run needs about 335 cycles
   always @(posedge clk)
      if (++cycles == 5000)
      begin
         num_errors++;
         tally_and_finish;
      end
endmodule // rx_data_link_extractor_tb

// *** dv/rx_link_sva.sv ***
// port assertions for the receive data link extractor
`timescale 1ns/100ps
module rx_link_sva
(
   input wire logic clk, rst, psel, penable, pwrite, pready, pslverr,
   input wire logic                 rxBitValid, rxData,
   input wire logic [rx_link_pkg::ADDR_W-1:0]    paddr,
   input wire logic [31:0]          prdata,
   input wire logic [rx_link_pkg::NUM_LINKS-1:0] linkData, linkStrobe
);
   import rx_link_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_strobe_has_bit: assert property (|linkStrobe |-> $past(rxBitValid))
      else $error("strobe without bit");
   a_data_is_bit: assert property (|linkStrobe |->
      (linkData & linkStrobe) == ({3{$past(rxData)}} & linkStrobe))
      else $error("wrong link bit");
   a_data_holds: assert property (!$past(rst) |->
      ((linkData ^ $past(linkData)) & ~linkStrobe) == 3'h0)
      else $error("link data moved");
   a_ready_high: assert property (psel |-> pready) else $error("ready low");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("stray error");
   a_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0
      && paddr inside {[12'h0A0:12'h0B8]} |-> !pslverr)
      else $error("error on mapped");
   a_unmapped_zero: assert property (psel && penable && !pwrite && pslverr
      |-> prdata == 32'h0) else $error("unmapped data");
   a_reset_quiet: assert property ($fell(rst) |-> linkStrobe == 3'h0
      && prdata == 32'h0) else $error("not cleared");
endmodule // rx_link_sva
bind rx_link_extractor rx_link_sva u_rx_link_sva (.clk, .rst, .psel,
   .penable, .pwrite, .pready, .pslverr, .rxBitValid, .rxData, .paddr,
   .prdata, .linkData, .linkStrobe);

// *** include/rx_link_pkg.sv ***
// constants and register map of the receive data link extractor
// ====================================================================
// Functional notes
// - each of three channels holds a 5-bit slot number choosing its slot.
// - in T1 the slot number is channel number minus one, values 0 to 23.
// - even qualifier set takes bits in even frames, clear takes none.
// - odd qualifier set takes bits in odd frames, clear takes none.
// - in E1 frame parity follows frame numbers 0 to 15 of the multiframe.
// - in T1 parity follows frames 1 to 12 (SF) or 1 to 24 (ESF).
// - an 8-bit mask passes only slot bits whose mask bit is one.
// - mask bit 7 is the first received bit, mask bit 0 the last.
// - with both qualifiers clear, slot and mask have no effect.
// - the three channels run independently, each feeding its own receiver.
// - channel one in T1 can route framer-located link bits as well as its slot bits.
package rx_link_pkg;
   // ================================================================
   // register offsets (printed offsets are not all word aligned: index)
   localparam logic [7:0] IDX_LINK1_CTRL  = 8'h28;
   localparam logic [7:0] IDX_LINK1_MASK  = 8'h29;
   localparam logic [7:0] IDX_LINK2_CTRL  = 8'h2A;
   localparam logic [7:0] IDX_LINK2_MASK  = 8'h2B;
   localparam logic [7:0] IDX_LINK3_CTRL  = 8'h2C;
   localparam logic [7:0] IDX_LINK3_MASK  = 8'h2D;
   localparam logic [7:0] IDX_MODE        = 8'h2E;
   localparam int         ADDR_LSB        = 2;
   localparam int         ADDR_W          = 12;
   // ================================================================
   // field positions
   localparam int         BIT_EVEN        = 7;
   localparam int         BIT_ODD         = 6;
   localparam int         BIT_FLT_EN      = 5;
   localparam int         SLOT_HI         = 4;
   localparam int         MODE_E1_BIT     = 0;
   // ================================================================
   // reset values
   localparam logic [7:0] RST_CTRL1       = 8'h20;
   localparam logic [7:0] RST_CTRL        = 8'h00;
   localparam logic [7:0] RST_MASK        = 8'h00;
   localparam logic [7:0] RST_MODE        = 8'h00;
   localparam logic [2:0] LAST_BIT        = 3'h7;
   localparam int         NUM_LINKS       = 3;
endpackage

// *** src/rx_link_extractor.sv ***
// receive data link extractor with APB register slave
`timescale 1ns/100ps
module rx_link_extractor
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [rx_link_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // receive framer position, one bit per valid cycle
   input  wire logic                  rxBitValid,
   input  wire logic                  rxData,
   input  wire logic [4:0]            rxSlot,
   input  wire logic [2:0]            rxBitIdx,
   input  wire logic [4:0]            rxFrameNum,
   input  wire logic                  rxFramingLinkBit,
   // hdlc receive unit feeds, one per link
   output logic      [rx_link_pkg::NUM_LINKS-1:0] linkData,
   output logic      [rx_link_pkg::NUM_LINKS-1:0] linkStrobe
);
   import rx_link_pkg::*;
   // ================================================================
   // registers
   logic [7:0]  ctrl_ff [NUM_LINKS];
   logic [7:0]  mask_ff [NUM_LINKS];
   logic [7:0]  mode_ff;
   logic [7:0]  regIdx;
   logic        access;
   logic        hit;
   logic [7:0]  rdVal;

   assign regIdx  = paddr[ADDR_LSB +: 8];
   assign access  = psel && penable;
   assign pready  = 1'b1;
   assign hit     = (regIdx >= IDX_LINK1_CTRL) && (regIdx <= IDX_MODE)
                    && (paddr[ADDR_LSB-1:0] == 2'h0)
                    && (paddr[ADDR_W-1:ADDR_LSB+8] == '0);
   assign pslverr = access && !hit;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_ff[0] <= RST_CTRL1;
         ctrl_ff[1] <= RST_CTRL;
         ctrl_ff[2] <= RST_CTRL;
         mask_ff[0] <= RST_MASK;
         mask_ff[1] <= RST_MASK;
         mask_ff[2] <= RST_MASK;
         mode_ff    <= RST_MODE;
      end
      else if (access && pwrite && hit)
      begin
         case (regIdx)
            IDX_LINK1_CTRL: ctrl_ff[0] <= pwdata[7:0];
            IDX_LINK1_MASK: mask_ff[0] <= pwdata[7:0];
            IDX_LINK2_CTRL: ctrl_ff[1] <= pwdata[7:0];
            IDX_LINK2_MASK: mask_ff[1] <= pwdata[7:0];
            IDX_LINK3_CTRL: ctrl_ff[2] <= pwdata[7:0];
            IDX_LINK3_MASK: mask_ff[2] <= pwdata[7:0];
            IDX_MODE:       mode_ff    <= pwdata[7:0];
            default:        mode_ff    <= mode_ff;
         endcase
      end
   end

   always_comb
   begin
      case (regIdx)
         IDX_LINK1_CTRL: rdVal = ctrl_ff[0];
         IDX_LINK1_MASK: rdVal = mask_ff[0];
         IDX_LINK2_CTRL: rdVal = ctrl_ff[1];
         IDX_LINK2_MASK: rdVal = mask_ff[1];
         IDX_LINK3_CTRL: rdVal = ctrl_ff[2];
         IDX_LINK3_MASK: rdVal = mask_ff[2];
         IDX_MODE:       rdVal = mode_ff;
         default:        rdVal = 8'h00;
      endcase
   end

   // read data registered once the setup cycle shows a read
   always_ff @(posedge clk)
   begin
      if (rst)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {24'h00_0000, rdVal};
   end

   // ================================================================
   // per-link extraction
   logic isE1;
   logic frameOdd;
   assign isE1 = mode_ff[MODE_E1_BIT];
   // e1 numbers frames 0..15, t1 1..12 or 1..24: the count value's lsb
   // is the parity in both cases, given the framer numbers as stated
   assign frameOdd = rxFrameNum[0];

   genvar g;
   generate
      for (g = 0; g < NUM_LINKS; g++)
      begin : gLink
         logic takeFrame;
         logic takeSlot;
         logic takeFlt;
         logic slotMatch;
         assign slotMatch = (rxSlot == ctrl_ff[g][SLOT_HI:0]);
         assign takeFrame = (ctrl_ff[g][BIT_EVEN] && !frameOdd)
                            || (ctrl_ff[g][BIT_ODD] && frameOdd);
         // mask bit 7 is the first bit received (index 0)
         assign takeSlot  = takeFrame && slotMatch
                            && mask_ff[g][LAST_BIT - rxBitIdx];
         // framer-located link only on link one, and never in e1
         if (g == 0)
         begin : gFlt
            assign takeFlt = ctrl_ff[0][BIT_FLT_EN] && !isE1
                             && rxFramingLinkBit;
         end
         else
         begin : gNoFlt
            assign takeFlt = 1'b0;
         end

         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               linkStrobe[g] <= 1'b0;
               linkData[g]   <= 1'b0;
            end
            else
            begin
               linkStrobe[g] <= rxBitValid && (takeSlot || takeFlt);
               if (rxBitValid && (takeSlot || takeFlt))
                  linkData[g] <= rxData;
            end
         end
      end
   endgenerate
endmodule // rx_link_extractor
